// >>> verilog/scg_pkg.sv
// Shared constants, encodings and carrier structs for the secure configuration gatekeeper.
// Assumes one configuration clock at 100 MHz and an active-low asynchronous reset.
package scg_pkg;

   // ==========================================================================
   // Widths.
   // ==========================================================================
   localparam int KEY_W  = 256;     // Symmetric decryption key held in fuses.
   localparam int HASH_W = 256;     // Hash of the signing public key.
   localparam int IR_W   = 4;       // Test port instruction register width.

   // ==========================================================================
   // Test port instruction codes (plain defaults, not tied to any real part).
   // ==========================================================================
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
   localparam logic [IR_W-1:0] IR_STATUS = 4'h5;
   localparam logic [IR_W-1:0] IR_SAMPLE = 4'h2;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;

   // ==========================================================================
   // Counts and codes.
   // ==========================================================================
   // Cycles after reset release before the synchronised fuse level is trusted.
   localparam logic [1:0] SETTLE_CYC   = 2'h3;
   localparam logic [2:0] ERR_NONE     = 3'h0;
   localparam logic [2:0] ERR_COMPRESS = 3'h1;
   localparam logic [2:0] ERR_PKEY     = 3'h2;
   localparam logic [2:0] ERR_SIG      = 3'h3;
   localparam logic [2:0] ERR_DECRYPT  = 3'h4;

   // ==========================================================================
   // Types.
   // ==========================================================================
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_HDR  = 4'h1,
      ST_KEY  = 4'h2,
      ST_SIG  = 4'h3,
      ST_DEC  = 4'h4,
      ST_LOAD = 4'h5,
      ST_USER = 4'h6,
      ST_HALT = 4'h7
   } scg_phase_e;

   // Levels arriving on pins from outside the clock domain.
   typedef struct packed {
      logic config_reset_n;
      logic flash_present;
      logic spi_active;
      logic jtag_block_fuse;
      logic fuse_program_supply;
   } scg_pins_s;

   // Security options taken from the bitstream header.
   typedef struct packed {
      logic compressed;
      logic encrypt;
      logic authen;
   } scg_hdr_s;

   typedef struct packed {
      scg_pins_s meta;
      scg_pins_s safe;
   } scg_sync_s;

   typedef struct packed {
      scg_phase_e        phase;
      logic              crst_prev;
      logic              want_dec;
      logic              spi_start;
      logic              dec_start;
      logic              rsa_start;
      logic [KEY_W-1:0]  dec_key;
      logic              auth_fail;
      logic [2:0]        err;
      logic [1:0]        settle;
      logic              fuse_seen;
      logic [IR_W-1:0]   ir_eff;
      logic              ir_reject;
   } scg_state_s;

   localparam scg_state_s STATE_RST = '{phase: ST_IDLE, ir_eff: IR_BYPASS, default: '0};

endpackage

// >>> verilog/scg_sync.sv
// Two-stage synchroniser for the pin levels of the gatekeeper.
// Assumes the pins are slow levels; no pulse shorter than two clocks is expected.
`timescale 1ns/1ns
module scg_sync (
   input  wire logic              mclk_in,   // Configuration clock.
   input  wire logic              nrst_in,   // Asynchronous reset, active low.
   input  wire scg_pkg::scg_pins_s pins_in,  // Raw pin levels.
   output      scg_pkg::scg_pins_s pins_out  // Levels safe to use in this domain.
);

   // ==========================================================================
   // State.
   // ==========================================================================
   scg_pkg::scg_sync_s s_q;   // Both stages.
   scg_pkg::scg_sync_s s_d;   // Next value.

   // The first stage feeds only the second stage.
   always_comb begin
      s_d      = s_q;
      s_d.meta = pins_in;
      s_d.safe = s_q.meta;
   end

   // Reset to all low, which reads as configuration reset held.
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pins_out = s_q.safe;

endmodule

// >>> verilog/scg_gatekeeper.sv
// Secure configuration gatekeeper: sequences decryption and authentication of a
// bitstream, gates user mode on the outcome and filters test port instructions.
// Assumes the cipher, signature engine and loader live outside and answer on this clock.
// How it works
// - Decrypt with the 256-bit fuse key.
// - Security with compressed bitstream halts configuration.
// - Decryption and authentication are independently selected.
// - Match key hash, then verify signature.
// - Good signature continues loading into user mode.
// - Bad signature halts, user mode never entered.
// - Blocked port allows only four instructions.
// - Once fuse is blown, blocking lifts only for one cycle as settle reaches SETTLE_CYC after nrst_in.
// - Reset rising edge starts active flash load unless the fuse supply is up.
`timescale 1ns/1ns
module scg_gatekeeper (
   input  wire logic                         mclk_in,               // 100 MHz clock.
   input  wire logic                         nrst_in,               // Async reset, low.
   input  wire logic                         config_reset_n_in,     // Pin, low holds reset.
   input  wire logic                         flash_present_in,      // Pin, flash has image.
   input  wire logic                         spi_active_in,         // Pin, active mode wired.
   input  wire logic                         jtag_block_fuse_in,    // Fuse level.
   input  wire logic                         fuse_program_supply_in,// Pin, supply up.
   input  wire logic [scg_pkg::KEY_W-1:0]    fuse_key_in,           // Fuse key array.
   input  wire logic [scg_pkg::HASH_W-1:0]   fuse_pkey_hash_in,     // Fused key hash.
   input  wire logic                         hdr_valid_in,          // Header strobe.
   input  wire scg_pkg::scg_hdr_s             hdr_in,                // Header options.
   input  wire logic                         pkey_valid_in,         // Key hash strobe.
   input  wire logic [scg_pkg::HASH_W-1:0]   pkey_hash_in,          // Hash of carried key.
   input  wire logic                         rsa_done_in,           // Signature check done.
   input  wire logic                         rsa_ok_in,             // Signature valid.
   input  wire logic                         dec_done_in,           // Decryption done.
   input  wire logic                         dec_ok_in,             // Tag matched.
   input  wire logic                         load_done_in,          // Loader finished.
   input  wire logic                         ir_update_in,          // New instruction strobe.
   input  wire logic [scg_pkg::IR_W-1:0]     ir_in,                 // Requested instruction.
   output      logic                         spi_start_out,         // Pulse, start flash read.
   output      logic                         rsa_start_out,         // Pulse, start signature.
   output      logic                         dec_start_out,         // Pulse, start decrypt.
   output      logic [scg_pkg::KEY_W-1:0]    dec_key_out,           // Key to the cipher.
   output      logic                         user_mode_out,         // Device in user mode.
   output      logic                         cfg_halt_out,          // Configuration stopped.
   output      logic                         auth_fail_out,         // Sticky failure flag.
   output      logic [2:0]                   err_out,               // Cause of halt.
   output      logic                         jtag_blocked_out,      // Test port restricted.
   output      logic [scg_pkg::IR_W-1:0]     ir_eff_out,            // Instruction in force.
   output      logic                         ir_reject_out          // Pulse, instr refused.
);

   // ==========================================================================
   // Pin synchronisation.
   // ==========================================================================
   scg_pkg::scg_pins_s pins_raw;   // Raw pins gathered.
   scg_pkg::scg_pins_s pins;       // Synchronised pins.

   assign pins_raw = '{config_reset_n:      config_reset_n_in,
                       flash_present:       flash_present_in,
                       spi_active:          spi_active_in,
                       jtag_block_fuse:     jtag_block_fuse_in,
                       fuse_program_supply: fuse_program_supply_in};

   scg_sync u_sync (
      .mclk_in  (mclk_in),
      .nrst_in  (nrst_in),
      .pins_in  (pins_raw),
      .pins_out (pins)
   );

   // ==========================================================================
   // State and derived terms.
   // ==========================================================================
   scg_pkg::scg_state_s st_q;      // All state of the block.
   scg_pkg::scg_state_s st_d;      // Next state.
   logic                crst_rise; // Configuration reset released this cycle.
   logic                blocked;   // Test port restriction in force.
   logic                allowed;   // Instruction survives restriction.

   assign crst_rise = pins.config_reset_n && !st_q.crst_prev;
   // Until the fuse level has settled the port is treated as blocked; once the
   // fuse has been seen blown nothing but nrst_in clears fuse_seen.
   assign blocked = st_q.fuse_seen || (st_q.settle != scg_pkg::SETTLE_CYC);
   assign allowed = (ir_in == scg_pkg::IR_IDCODE) || (ir_in == scg_pkg::IR_STATUS) ||
                    (ir_in == scg_pkg::IR_SAMPLE) || (ir_in == scg_pkg::IR_BYPASS);

   // ==========================================================================
   // Next-state logic.
   // ==========================================================================
   always_comb begin
      st_d           = st_q;
      st_d.crst_prev = pins.config_reset_n;
      st_d.spi_start = 1'b0;
      st_d.rsa_start = 1'b0;
      st_d.dec_start = 1'b0;
      st_d.ir_reject = 1'b0;

      // Fuse settle and sticky blocking.
      if (st_q.settle != scg_pkg::SETTLE_CYC) begin
         st_d.settle = st_q.settle + 2'h1;
      end
      if (pins.jtag_block_fuse && st_q.settle == scg_pkg::SETTLE_CYC) begin
         st_d.fuse_seen = 1'b1;
      end

      // Instruction filter: a refused instruction is replaced by bypass.
      if (ir_update_in) begin
         if (blocked && !allowed) begin
            st_d.ir_eff    = scg_pkg::IR_BYPASS;
            st_d.ir_reject = 1'b1;
         end else begin
            st_d.ir_eff = ir_in;
         end
      end

      // Configuration sequence.
      if (!pins.config_reset_n) begin
         // Holding reset ends any flow and clears the failure record.
         st_d.phase     = scg_pkg::ST_IDLE;
         st_d.auth_fail = 1'b0;
         st_d.err       = scg_pkg::ERR_NONE;
      end else begin
         unique case (st_q.phase)
            scg_pkg::ST_IDLE: begin
               // A release while the fuse supply is up is ignored, since the
               // programmer is then blowing fuses, not configuring.
               if (crst_rise && !pins.fuse_program_supply) begin
                  st_d.phase     = scg_pkg::ST_HDR;
                  st_d.spi_start = pins.flash_present && pins.spi_active;
               end
            end
            scg_pkg::ST_HDR: begin
               if (hdr_valid_in) begin
                  st_d.want_dec = hdr_in.encrypt;
                  if (hdr_in.compressed && (hdr_in.encrypt || hdr_in.authen)) begin
                     st_d.phase = scg_pkg::ST_HALT;
                     st_d.err   = scg_pkg::ERR_COMPRESS;
                  end else if (hdr_in.authen) begin
                     st_d.phase = scg_pkg::ST_KEY;
                  end else if (hdr_in.encrypt) begin
                     st_d.phase     = scg_pkg::ST_DEC;
                     st_d.dec_start = 1'b1;
                     st_d.dec_key   = fuse_key_in;
                  end else begin
                     st_d.phase = scg_pkg::ST_LOAD;
                  end
               end
            end
            scg_pkg::ST_KEY: begin
               if (pkey_valid_in) begin
                  if (pkey_hash_in == fuse_pkey_hash_in) begin
                     st_d.phase     = scg_pkg::ST_SIG;
                     st_d.rsa_start = 1'b1;
                  end else begin
                     st_d.phase     = scg_pkg::ST_HALT;
                     st_d.auth_fail = 1'b1;
                     st_d.err       = scg_pkg::ERR_PKEY;
                  end
               end
            end
            scg_pkg::ST_SIG: begin
               if (rsa_done_in) begin
                  if (!rsa_ok_in) begin
                     st_d.phase     = scg_pkg::ST_HALT;
                     st_d.auth_fail = 1'b1;
                     st_d.err       = scg_pkg::ERR_SIG;
                  end else if (st_q.want_dec) begin
                     st_d.phase     = scg_pkg::ST_DEC;
                     st_d.dec_start = 1'b1;
                     st_d.dec_key   = fuse_key_in;
                  end else begin
                     st_d.phase = scg_pkg::ST_LOAD;
                  end
               end
            end
            scg_pkg::ST_DEC: begin
               // A wrong key fails the tag and must never reach user mode.
               if (dec_done_in) begin
                  if (dec_ok_in) begin
                     st_d.phase = scg_pkg::ST_LOAD;
                  end else begin
                     st_d.phase = scg_pkg::ST_HALT;
                     st_d.err   = scg_pkg::ERR_DECRYPT;
                  end
               end
            end
            scg_pkg::ST_LOAD: begin
               if (load_done_in) begin
                  st_d.phase = scg_pkg::ST_USER;
               end
            end
            scg_pkg::ST_USER: begin
               st_d.phase = scg_pkg::ST_USER;
            end
            scg_pkg::ST_HALT: begin
               st_d.phase = scg_pkg::ST_HALT;
            end
            default: begin
               st_d.phase = scg_pkg::ST_HALT;
            end
         endcase
      end
   end

   // ==========================================================================
   // State register.
   // ==========================================================================
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= scg_pkg::STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================================
   // Outputs.
   // ==========================================================================
   assign spi_start_out    = st_q.spi_start;
   assign rsa_start_out    = st_q.rsa_start;
   assign dec_start_out    = st_q.dec_start;
   assign dec_key_out      = st_q.dec_key;
   assign user_mode_out    = (st_q.phase == scg_pkg::ST_USER);
   assign cfg_halt_out     = (st_q.phase == scg_pkg::ST_HALT);
   assign auth_fail_out    = st_q.auth_fail;
   assign err_out          = st_q.err;
   assign jtag_blocked_out = blocked;
   assign ir_eff_out       = st_q.ir_eff;
   assign ir_reject_out    = st_q.ir_reject;

   // ==========================================================================
   // Checks.
   // ==========================================================================
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_hdr_secure_compressed;
      st_q.phase == scg_pkg::ST_HDR && hdr_valid_in && pins.config_reset_n &&
      hdr_in.compressed && (hdr_in.encrypt || hdr_in.authen);
   endsequence

   sequence s_auto_release;
      crst_rise && st_q.phase == scg_pkg::ST_IDLE && !pins.fuse_program_supply;
   endsequence

   a_decrypt_key_used: assert property ($rose(dec_start_out) |-> dec_key_out == fuse_key_in)
      else $error("Decryption started without the fuse key.");
   a_compress_refused: assert property (s_hdr_secure_compressed |=>
      cfg_halt_out && err_out == scg_pkg::ERR_COMPRESS)
      else $error("Compressed secured bitstream was not refused.");
   a_encrypt_only_path: assert property (st_q.phase == scg_pkg::ST_HDR && hdr_valid_in &&
      pins.config_reset_n && hdr_in.encrypt && !hdr_in.authen && !hdr_in.compressed
      |=> dec_start_out && !rsa_start_out)
      else $error("Encryption-only flow did not go straight to decryption.");
   a_key_mismatch_fails: assert property (st_q.phase == scg_pkg::ST_KEY && pkey_valid_in &&
      pins.config_reset_n && pkey_hash_in != fuse_pkey_hash_in |=> auth_fail_out ##1 auth_fail_out)
      else $error("Public key hash mismatch did not fail authentication.");
   a_sig_pass_loads: assert property (st_q.phase == scg_pkg::ST_SIG && rsa_done_in &&
      rsa_ok_in && !st_q.want_dec && pins.config_reset_n |=> st_q.phase == scg_pkg::ST_LOAD)
      else $error("Valid signature did not continue loading.");
   a_fail_no_user: assert property (auth_fail_out |-> !user_mode_out && cfg_halt_out)
      else $error("User mode reached after failed authentication.");
   a_block_filter: assert property (ir_update_in && blocked && !allowed |=>
      ir_eff_out == scg_pkg::IR_BYPASS && ir_reject_out)
      else $error("Blocked port accepted a restricted instruction.");
   a_block_sticky: assert property (st_q.fuse_seen |=> jtag_blocked_out [*3])
      else $error("Test port blocking was lifted.");
   a_supply_no_start: assert property (pins.fuse_program_supply |=> !spi_start_out)
      else $error("Configuration started while fuse supply was up.");
   a_auto_spi_start: assert property ((s_auto_release and
      (pins.flash_present && pins.spi_active)) |=> spi_start_out ##1 !spi_start_out)
      else $error("Flash load did not start on reset release.");
   a_fail_held: assert property ($rose(auth_fail_out) && pins.config_reset_n
      |=> auth_fail_out [*4])
      else $error("Authentication failure flag dropped early.");

endmodule

// >>> sim/scg_partner.sv
// Behavioural partner: the signature engine and the cipher that answer start pulses.
// Assumes the gatekeeper's clock and reset; the bench chooses each verdict and delay.
`timescale 1ns/1ns
module scg_partner (
   input  wire logic       mclk_in,      // Shared clock.
   input  wire logic       nrst_in,      // Async reset, active low.
   input  wire logic       rsa_start_in, // Pulse, start signature check.
   input  wire logic       dec_start_in, // Pulse, start decryption.
   input  wire logic       rsa_good_in,  // Verdict the signature engine will give.
   input  wire logic       dec_good_in,  // Verdict the cipher will give.
   input  wire logic [2:0] lat_in,       // Extra answer delay in cycles.
   output      logic       rsa_done_out, // Pulse, signature verdict ready.
   output      logic       rsa_ok_out,   // Verdict, meaningful only with done.
   output      logic       dec_done_out, // Pulse, decryption verdict ready.
   output      logic       dec_ok_out    // Verdict, meaningful only with done.
);
   logic [3:0] rsa_cnt_q; // Cycles left until the signature verdict.
   logic [3:0] dec_cnt_q; // Cycles left until the decryption verdict.
   logic       junk_q;    // Toggles so a stale verdict line never looks settled.
   // ==========================================================================
   // Answer timers.
   // ==========================================================================
   // A start reloads its timer; done fires when the timer reaches one.
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rsa_cnt_q <= 4'h0;
         dec_cnt_q <= 4'h0;
         junk_q    <= 1'b0;
      end else begin
         junk_q    <= ~junk_q;
         rsa_cnt_q <= rsa_start_in ? {1'b0, lat_in} + 4'h1 : rsa_cnt_q - {3'h0, rsa_cnt_q != 4'h0};
         dec_cnt_q <= dec_start_in ? {1'b0, lat_in} + 4'h1 : dec_cnt_q - {3'h0, dec_cnt_q != 4'h0};
      end
   end
   // Outside a done pulse the verdict lines carry junk, as a real engine would.
   assign rsa_done_out = (rsa_cnt_q == 4'h1);
   assign rsa_ok_out   = rsa_done_out ? rsa_good_in : junk_q;
   assign dec_done_out = (dec_cnt_q == 4'h1);
   assign dec_ok_out   = dec_done_out ? dec_good_in : ~junk_q;
endmodule

// >>> sim/scg_gatekeeper_tb.sv
// Self-checking bench for the gatekeeper: random and corner configuration runs, filter sweeps.
// Assumes the partner model answers the signature and cipher starts on the same clock.
`timescale 1ns/1ns
module scg_gatekeeper_tb;
   // ==========================================================================
   // Signals, named as the ports they drive or watch.
   // ==========================================================================
   logic mclk_in = 1'b0, nrst_in, config_reset_n_in, flash_present_in, spi_active_in;
   logic jtag_block_fuse_in, fuse_program_supply_in, hdr_valid_in, pkey_valid_in;
   logic rsa_done_in, rsa_ok_in, dec_done_in, dec_ok_in, load_done_in, ir_update_in;
   logic [255:0]      fuse_key_in, fuse_pkey_hash_in, pkey_hash_in, dec_key_out;
   scg_pkg::scg_hdr_s hdr_in;
   logic [3:0]        ir_in, ir_eff_out;
   logic [2:0]        err_out, lat;
   logic spi_start_out, rsa_start_out, dec_start_out, user_mode_out, cfg_halt_out;
   logic auth_fail_out, jtag_blocked_out, ir_reject_out, rsa_good, dec_good;
   int   seed = 32'h4E7A9896;             // Fixed seed keeps every run repeatable.
   int   failures = 0, n_checks = 0, n_spi, n_rsa, n_dec;

   scg_gatekeeper scg_gatekeeper_i (.mclk_in, .nrst_in, .config_reset_n_in, .flash_present_in,
      .spi_active_in, .jtag_block_fuse_in, .fuse_program_supply_in, .fuse_key_in,
      .fuse_pkey_hash_in, .hdr_valid_in, .hdr_in, .pkey_valid_in, .pkey_hash_in, .rsa_done_in,
      .rsa_ok_in, .dec_done_in, .dec_ok_in, .load_done_in, .ir_update_in, .ir_in,
      .spi_start_out, .rsa_start_out, .dec_start_out, .dec_key_out, .user_mode_out,
      .cfg_halt_out, .auth_fail_out, .err_out, .jtag_blocked_out, .ir_eff_out, .ir_reject_out);
   scg_partner scg_partner_i (.mclk_in, .nrst_in, .rsa_start_in(rsa_start_out),
      .dec_start_in(dec_start_out), .rsa_good_in(rsa_good), .dec_good_in(dec_good),
      .lat_in(lat), .rsa_done_out(rsa_done_in), .rsa_ok_out(rsa_ok_in),
      .dec_done_out(dec_done_in), .dec_ok_out(dec_ok_in));

   always #5 mclk_in = ~mclk_in;

   // ==========================================================================
   // Checking helpers.
   // ==========================================================================
   task automatic check_val(input string name, input logic [255:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Counts start pulses; the key handed to the cipher must be the fuse key.
   always @(posedge mclk_in) begin
      if (spi_start_out === 1'b1) n_spi++;
      if (rsa_start_out === 1'b1) n_rsa++;
      if (dec_start_out === 1'b1) begin
         n_dec++;
         check_val("dec_key", dec_key_out, fuse_key_in);
      end
   end

   // Outcome {user, halt, auth_fail, err} of one run, worked out from the options.
   function automatic logic [5:0] expect_cfg(input logic [2:0] h, input logic m, s, d, sup);
      if (sup) return 6'h00;
      if (h[2] && (h[1] || h[0])) return {3'h2, scg_pkg::ERR_COMPRESS};
      if (h[0] && !m) return {3'h3, scg_pkg::ERR_PKEY};
      if (h[0] && !s) return {3'h3, scg_pkg::ERR_SIG};
      if (h[1] && !d) return {3'h2, scg_pkg::ERR_DECRYPT};
      return {3'h4, scg_pkg::ERR_NONE};
   endfunction

   // One configuration: reset pulse, header, optional key hash, then wait for the verdict.
   task automatic run_cfg(input logic [2:0] h, input logic m, s, d, sup);
      logic [5:0] e;
      int         k;
      e = expect_cfg(h, m, s, d, sup);
      @(posedge mclk_in);
      #1 config_reset_n_in = 1'b0;
      flash_present_in = 1'($random(seed));
      spi_active_in = 1'($random(seed));
      lat = 3'($random(seed));
      rsa_good = s;
      dec_good = d;
      fuse_program_supply_in = sup;
      repeat (4) @(posedge mclk_in);
      #1 check_val("auth_fail_clear", 256'(auth_fail_out), 256'h0);
      config_reset_n_in = 1'b1;
      n_spi = 0;
      n_rsa = 0;
      n_dec = 0;
      repeat (6) @(posedge mclk_in);
      #1 hdr_valid_in = 1'b1;
      hdr_in = scg_pkg::scg_hdr_s'(h);
      @(posedge mclk_in);
      #1 hdr_valid_in = 1'b0;
      pkey_valid_in = h[0];
      pkey_hash_in = m ? fuse_pkey_hash_in : ~fuse_pkey_hash_in;
      @(posedge mclk_in);
      #1 pkey_valid_in = 1'b0;
      load_done_in = 1'b1;
      k = 0;
      while (user_mode_out !== 1'b1 && cfg_halt_out !== 1'b1 && k < 60) begin
         @(posedge mclk_in);
         k++;
      end
      repeat (4) @(posedge mclk_in);
      #1 check_val("user", 256'(user_mode_out), 256'(e[5]));
      check_val("halt", 256'(cfg_halt_out), 256'(e[4]));
      check_val("auth_fail", 256'(auth_fail_out), 256'(e[3]));
      check_val("err", 256'(err_out), 256'(e[2:0]));
      check_val("spi_start", 256'(n_spi), 256'(flash_present_in & spi_active_in & !sup));
      check_val("rsa_start", 256'(n_rsa), 256'(!sup && m && (h == 3'h1 || h == 3'h3)));
      check_val("dec_start", 256'(n_dec), 256'(!sup && h[2:1] == 2'h1 && (!h[0] || m && s)));
      load_done_in = 1'b0;
   endtask

   // One instruction update; a blocked port keeps only the four permitted codes.
   task automatic ir_try(input logic [3:0] c, input logic blk);
      logic ok;
      ok = !blk || c == scg_pkg::IR_IDCODE || c == scg_pkg::IR_STATUS
           || c == scg_pkg::IR_SAMPLE || c == scg_pkg::IR_BYPASS;
      @(posedge mclk_in);
      #1 ir_update_in = 1'b1;
      ir_in = c;
      @(posedge mclk_in);
      #1 ir_update_in = 1'b0;
      check_val("ir_eff", 256'(ir_eff_out), 256'(ok ? c : scg_pkg::IR_BYPASS));
      check_val("ir_reject", 256'(ir_reject_out), 256'(!ok));
   endtask

   // ==========================================================================
   // Main sequence and watchdog.
   // ==========================================================================
   initial begin
      {nrst_in, config_reset_n_in, flash_present_in, spi_active_in, jtag_block_fuse_in} = '0;
      {fuse_program_supply_in, hdr_valid_in, pkey_valid_in, load_done_in, ir_update_in} = '0;
      {hdr_in, ir_in, lat, rsa_good, dec_good, pkey_hash_in} = '0;
      for (int i = 0; i < 8; i++) begin
         fuse_key_in[32*i +: 32] = $random(seed);
         fuse_pkey_hash_in[32*i +: 32] = $random(seed);
      end
      repeat (4) @(posedge mclk_in);
      #1 nrst_in = 1'b1;
      repeat (5) @(posedge mclk_in);
      #1 check_val("blocked_off", 256'(jtag_blocked_out), 256'h0);
      // Test port traffic and configuration runs never overlap.
      for (int c = 0; c < 16; c++) ir_try(4'(c), 1'b0);
      for (int i = 0; i < 8; i++) run_cfg(3'(i), 1'b1, 1'b1, 1'b1, 1'b0);
      run_cfg(3'h3, 1'b0, 1'b1, 1'b1, 1'b0);
      run_cfg(3'h3, 1'b1, 1'b0, 1'b1, 1'b0);
      run_cfg(3'h2, 1'b1, 1'b1, 1'b0, 1'b0);
      // With the fuse supply up the release is ignored and no start pulse is given.
      run_cfg(3'h3, 1'b1, 1'b1, 1'b1, 1'b1);
      repeat (20) run_cfg(3'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                          1'($random(seed)), 1'b0);
      jtag_block_fuse_in = 1'b1;
      repeat (4) @(posedge mclk_in);
      #1 check_val("blocked_on", 256'(jtag_blocked_out), 256'h1);
      for (int c = 0; c < 16; c++) ir_try(4'(c), 1'b1);
      jtag_block_fuse_in = 1'b0;
      run_cfg(3'h0, 1'b1, 1'b1, 1'b1, 1'b0);
      check_val("blocked_kept", 256'(jtag_blocked_out), 256'h1);
      repeat (8) ir_try(4'($random(seed)), 1'b1);
      conclude();
   end

   // A hang runs into this limit, well beyond the thousand or so cycles the tests take.
   initial begin
      #300000;
      failures++;
      conclude();
   end
endmodule
